/* sar_pkg.sv */
// Constants, register map and types of the converter control block.
package sar_pkg;

	// Width of one conversion result.
	localparam int DATA_W = 20;

	// Timing of the internal conversion sequence.
	localparam int CLK_PERIOD_NS = 25;
	localparam int CONV_TIME_NS  = 2000;
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_CYCLES   = CONV_CYCLES / DATA_W;
	localparam logic [2:0] STEP_LAST = 3'(STEP_CYCLES - 1);
	localparam logic [4:0] BIT_MSB   = 5'(DATA_W - 1);
	localparam logic [4:0] BIT_LSB   = 5'h0;

	// Timing that the host keeps.
	localparam int CNV_LOW_MIN_NS = 20;
	localparam int SCK_QUIET_NS   = 20;

	// Code values.
	localparam logic [19:0] SIGN_FLIP = 20'h80000;
	localparam logic [19:0] CODE_MAX  = 20'h7FFFF;
	localparam logic [19:0] CODE_MIN  = 20'h80000;
	localparam logic [19:0] CODE_ZERO = 20'h00000;

	// Register byte addresses.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SAMPLE = 8'h08;
	localparam logic [7:0] ADDR_RESULT = 8'h0C;
	localparam logic [7:0] ADDR_COUNT  = 8'h10;

	// Field positions and reset values.
	localparam int CTRL_PDN_BIT     = 0;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_AWAKE_BIT   = 1;
	localparam int STAT_CHAIN_BIT   = 2;
	localparam int STAT_COMP_BIT    = 3;
	localparam int STAT_RDEN_BIT    = 4;
	localparam logic       CTRL_PDN_RESET = 1'h1;
	localparam logic [19:0] SAMPLE_RESET  = 20'h00000;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;

	// Converter states.
	typedef enum logic [1:0] {
		SAR_SLEEP,
		SAR_ACQUIRE,
		SAR_CONVERT
	} sar_state_t;

endpackage

/* sar_adc_ctrl.sv */
// Conversion control, successive approximation and serial readout of the converter.
//
// Our own choices: the APB slave port and the register offsets.

// What this block does
// - Chain select low: shared pin acts as read enable for the serial output.
// - Chain select high: shared pin acts as serial input from an upstream converter.
// - In chain mode output carries own result, then upstream data shifted through.
// - Each serial clock rising edge shifts one bit out, most significant first.
// - Results leave the device as two's-complement numbers.
// - Each conversion yields a 20-bit code prepared for transfer at completion.
// - A rising convert edge outside a running conversion wakes the device and starts a conversion.
// - Busy rises when a conversion starts and falls when it has finished.
// - Compression select high: no compression, full plus-minus reference span.
// - Compression select low: full scale covers 10 to 90 percent of range.
// - With compression on the result is rescaled digitally onto the full code span.
// - Conversion is timed internally; no conversion clock from the host.
// - The device powers down by itself between conversions.
// - Each result is readable right after its own conversion, no pipeline delay.
// - Acquisition alternates with a 20-step binary successive approximation.
module sar_adc_ctrl
	import sar_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Converter pins.
	input  wire logic        convert_start_in,
	input  wire logic        chain_select_in,
	input  wire logic        compression_select_in,
	output logic             busy_out,
	// Serial link.
	input  wire logic        sck_in,
	input  wire logic        read_enable_or_chain_in,
	output logic             sdo_out,
	output logic             sdo_oe_out
);
	import sar_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Functions.

	// Address decode used by the error answer and the bus checks.
	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr == ADDR_CTRL) || (addr == ADDR_STATUS) || (addr == ADDR_SAMPLE)
			|| (addr == ADDR_RESULT) || (addr == ADDR_COUNT);
	endfunction

	// Result word from the raw code, stretched by five quarters when compressing.
	function automatic logic [19:0] shape_code(input logic [19:0] raw, input logic comp);
		logic signed [21:0] wide;
		wide = 22'(signed'(raw)) + 22'(signed'(raw) >>> 2);
		if (!comp) begin
			shape_code = raw;
		end else if (wide > 22'(signed'(CODE_MAX))) begin
			shape_code = CODE_MAX;
		end else if (wide < 22'(signed'(CODE_MIN))) begin
			shape_code = CODE_MIN;
		end else begin
			shape_code = wide[19:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic conv_s1_r, conv_s2_r, conv_s3_r;
	logic chain_s1_r, chain_s2_r;
	logic comp_s1_r, comp_s2_r;
	logic rden_s1_r, rden_s2_r;

	always_ff @(posedge clk_in) begin
		conv_s1_r  <= convert_start_in;
		conv_s2_r  <= conv_s1_r;
		conv_s3_r  <= conv_s2_r;
		chain_s1_r <= chain_select_in;
		chain_s2_r <= chain_s1_r;
		comp_s1_r  <= compression_select_in;
		comp_s2_r  <= comp_s1_r;
		rden_s1_r  <= read_enable_or_chain_in;
		rden_s2_r  <= rden_s1_r;
	end

	wire conv_edge = conv_s2_r & ~conv_s3_r;
	wire chain_on  = chain_s2_r;
	wire comp_on   = ~comp_s2_r;

	////////////////////////////////////////////////////////////////////////////////
	// Registers written by software.

	logic        pdn_en_r;
	logic [19:0] sample_r;
	logic [31:0] prdata_r;

	wire apb_setup = psel_in & ~penable_in;
	wire apb_wr    = psel_in & penable_in & pwrite_in;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			pdn_en_r <= CTRL_PDN_RESET;
			sample_r <= SAMPLE_RESET;
		end else begin
			if (apb_wr && paddr_in == ADDR_CTRL) begin
				pdn_en_r <= pwdata_in[CTRL_PDN_BIT];
			end
			if (apb_wr && paddr_in == ADDR_SAMPLE) begin
				sample_r <= pwdata_in[19:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer.

	sar_state_t  state_r, state_nxt;
	logic [19:0] hold_r;
	logic [19:0] acc_r;
	logic [4:0]  bit_r;
	logic [2:0]  step_r;
	logic [19:0] result_r;
	logic        comp_used_r;
	logic        gen_r;
	logic [15:0] count_r;

	wire converting = (state_r == SAR_CONVERT);
	wire start      = conv_edge & ~converting;
	wire step_end   = converting & (step_r == STEP_LAST);
	wire last_bit   = (bit_r == BIT_LSB);
	wire conv_done  = step_end & last_bit;

	wire [19:0] hold_u    = hold_r ^ SIGN_FLIP;
	wire [19:0] trial     = acc_r | (20'h00001 << bit_r);
	wire [19:0] acc_dec   = (hold_u >= trial) ? trial : acc_r;
	wire [19:0] raw_code  = acc_dec ^ SIGN_FLIP;
	wire [19:0] new_code  = shape_code(raw_code, comp_on);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			SAR_SLEEP, SAR_ACQUIRE: begin
				if (start) begin
					state_nxt = SAR_CONVERT;
				end
			end
			SAR_CONVERT: begin
				if (conv_done) begin
					state_nxt = pdn_en_r ? SAR_SLEEP : SAR_ACQUIRE;
				end
			end
			default: begin
				state_nxt = SAR_SLEEP;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_r <= SAR_SLEEP;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Acquisition ends at the start edge; the sampled value is held.
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			hold_r <= CODE_ZERO;
			acc_r  <= CODE_ZERO;
			bit_r  <= BIT_MSB;
			step_r <= 3'h0;
		end else if (start) begin
			hold_r <= sample_r;
			acc_r  <= CODE_ZERO;
			bit_r  <= BIT_MSB;
			step_r <= 3'h0;
		end else if (converting) begin
			step_r <= step_end ? 3'h0 : step_r + 3'h1;
			if (step_end) begin
				acc_r <= acc_dec;
				bit_r <= last_bit ? BIT_MSB : bit_r - 5'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			result_r    <= CODE_ZERO;
			comp_used_r <= 1'h0;
			gen_r       <= 1'h0;
			count_r     <= COUNT_RESET;
		end else if (conv_done) begin
			result_r    <= new_code;
			comp_used_r <= comp_on;
			gen_r       <= ~gen_r;
			count_r     <= count_r + 16'h1;
		end
	end

	assign busy_out = converting;

	////////////////////////////////////////////////////////////////////////////////
	// Output enable of the serial pin.

	logic oe_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			oe_r <= 1'h0;
		end else begin
			oe_r <= chain_on | ~rden_s2_r;
		end
	end

	assign sdo_oe_out = oe_r;

	////////////////////////////////////////////////////////////////////////////////
	// Serial clock domain.

	logic        krst_s1_r, krst_s2_r;
	logic        seen_r;
	logic [19:0] shift_r;

	always_ff @(posedge sck_in) begin
		krst_s1_r <= resetn_in;
		krst_s2_r <= krst_s1_r;
	end

	// A new result stays in the core until the first serial edge takes it over.
	wire fresh = gen_r ^ seen_r;

	always_ff @(posedge sck_in) begin
		if (!krst_s2_r) begin
			seen_r  <= 1'h0;
			shift_r <= CODE_ZERO;
		end else if (fresh) begin
			seen_r  <= gen_r;
			shift_r <= {result_r[18:0], read_enable_or_chain_in};
		end else begin
			shift_r <= {shift_r[18:0], read_enable_or_chain_in};
		end
	end

	assign sdo_out = fresh ? result_r[19] : shift_r[19];

	////////////////////////////////////////////////////////////////////////////////
	// APB read and answer.

	wire [31:0] status_word = {27'h0, rden_s2_r, comp_on, chain_on,
		(state_r != SAR_SLEEP), converting};
	wire [31:0] read_mux =
		(paddr_in == ADDR_CTRL)   ? {31'h0, pdn_en_r} :
		(paddr_in == ADDR_STATUS) ? status_word :
		(paddr_in == ADDR_SAMPLE) ? {12'h0, sample_r} :
		(paddr_in == ADDR_RESULT) ? {12'h0, result_r} :
		(paddr_in == ADDR_COUNT)  ? {16'h0, count_r} : 32'h0;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			prdata_r <= 32'h0;
		end else if (apb_setup) begin
			prdata_r <= read_mux;
		end
	end

	assign prdata_out  = prdata_r;
	assign pready_out  = 1'h1;
	assign pslverr_out = psel_in & penable_in & ~is_mapped(paddr_in);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [7:0] busy_cnt_r;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			busy_cnt_r <= 8'h0;
		end else begin
			busy_cnt_r <= converting ? busy_cnt_r + 8'h1 : 8'h0;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	chk_busy_start: assert property (start |=> busy_out && hold_r == $past(sample_r))
		else $error("Busy did not rise on a convert edge.");
	chk_busy_length: assert property ($fell(busy_out) |-> $past(busy_cnt_r) == 8'(CONV_CYCLES - 1))
		else $error("Conversion did not last its fixed time.");
	chk_busy_hold: assert property (converting && conv_edge |=> converting && hold_r == $past(hold_r))
		else $error("A convert edge disturbed a running conversion.");
	chk_plain_code: assert property ($fell(busy_out) && !comp_used_r |-> result_r == hold_r)
		else $error("Uncompressed result differs from the held sample.");
	chk_comp_code: assert property ($fell(busy_out) && comp_used_r |-> result_r == shape_code(hold_r, 1'h1))
		else $error("Compressed result is scaled wrongly.");
	chk_result_ready: assert property ($fell(busy_out) |-> gen_r != $past(gen_r) && count_r == $past(count_r) + 16'h1)
		else $error("Result not released at conversion end.");
	chk_auto_sleep: assert property ($fell(busy_out) && $past(pdn_en_r) |-> state_r == SAR_SLEEP)
		else $error("Device stayed awake after conversion.");
	chk_oe_normal: assert property (##2 (!$past(chain_on) && $past(rden_s2_r)) |-> !sdo_oe_out)
		else $error("Serial output driven while read enable is high.");
	chk_oe_chain: assert property (##2 $past(chain_on) |-> sdo_oe_out)
		else $error("Serial output not driven in chain mode.");
	chk_apb_err: assert property (psel_in && penable_in && !is_mapped(paddr_in) |-> pslverr_out && pready_out)
		else $error("Unmapped access not refused.");
	chk_shift_msb: assert property (@(posedge sck_in) disable iff (!krst_s2_r)
		$past(fresh) |-> shift_r[19] == $past(result_r[18]))
		else $error("Second bit out is not the next result bit.");

	// Sequencer checks.
	chk_start_take: assert property (conv_edge && !converting |=> converting)
		else $error("Convert edge did not start a conversion.");
	chk_acc_clear: assert property (start |=> acc_r == CODE_ZERO && bit_r == BIT_MSB)
		else $error("Approximation did not restart from the top bit.");
	chk_step_limit: assert property (step_r <= STEP_LAST)
		else $error("Step counter ran past its last value.");
	chk_bit_walk: assert property (step_end && !last_bit |=> bit_r == $past(bit_r) - 5'h1)
		else $error("Trial bit did not move down by one.");
	chk_acc_steady: assert property (converting && !step_end |=> acc_r == $past(acc_r))
		else $error("Approximation changed between decisions.");
	chk_hold_steady: assert property (converting |=> hold_r == $past(hold_r))
		else $error("Held sample changed during conversion.");
	chk_busy_done: assert property (conv_done |=> !busy_out)
		else $error("Busy stayed high after the last decision.");
	chk_awake_wait: assert property ($fell(busy_out) && !$past(pdn_en_r)
		|-> state_r == SAR_ACQUIRE)
		else $error("Device slept although auto power-down was off.");
	chk_sleep_stay: assert property (state_r == SAR_SLEEP && !start |=> state_r == SAR_SLEEP)
		else $error("Device woke without a convert edge.");
	chk_comp_track: assert property (conv_done |=> comp_used_r == $past(comp_on))
		else $error("Compression mode not taken at conversion end.");
	chk_result_stand: assert property (!conv_done |=> result_r == $past(result_r))
		else $error("Result changed outside a conversion end.");
	chk_count_stand: assert property (!conv_done |=> count_r == $past(count_r))
		else $error("Conversion count changed outside a conversion end.");

	// Bus checks.
	chk_ctrl_write: assert property (apb_wr && paddr_in == ADDR_CTRL
		|=> pdn_en_r == $past(pwdata_in[CTRL_PDN_BIT]))
		else $error("Control write did not land.");
	chk_sample_write: assert property (apb_wr && paddr_in == ADDR_SAMPLE
		|=> sample_r == $past(pwdata_in[19:0]))
		else $error("Sample write did not land.");
	chk_read_load: assert property (apb_setup |=> prdata_out == $past(read_mux))
		else $error("Read data not loaded in the setup cycle.");
	chk_read_hold: assert property (!apb_setup |=> prdata_out == $past(prdata_out))
		else $error("Read data changed outside a setup cycle.");
	chk_err_mapped: assert property (psel_in && penable_in && is_mapped(paddr_in) |-> !pslverr_out)
		else $error("Mapped access refused.");
	chk_err_idle: assert property (!psel_in |-> !pslverr_out)
		else $error("Slave error raised without a transfer.");

	// Serial clock checks.
	chk_shift_walk: assert property (@(posedge sck_in) disable iff (!krst_s2_r)
		$past(krst_s2_r) && !$past(fresh) |-> shift_r[19] == $past(shift_r[18]))
		else $error("Serial word did not move on by one bit.");
	chk_chain_take: assert property (@(posedge sck_in) disable iff (!krst_s2_r)
		$past(krst_s2_r) |-> shift_r[0] == $past(read_enable_or_chain_in))
		else $error("Serial input bit not taken in.");

	cov_plain: cover property ($fell(busy_out) && !comp_used_r);
	cov_awake: cover property (state_r == SAR_ACQUIRE ##1 state_r == SAR_CONVERT);
	cov_comp: cover property ($fell(busy_out) && comp_used_r);
	cov_wake: cover property (state_r == SAR_SLEEP ##1 state_r == SAR_CONVERT);
	cov_chain: cover property (@(posedge sck_in) chain_on && fresh);

endmodule

/* sar_host_model.sv */
// Host controller model that drives the convert pin and the serial link.
module sar_host_model (
	// Core clock and converter outputs.
	input  wire logic clk_in,
	input  wire logic busy_in,
	input  wire logic sdo_in,
	// Pins towards the converter.
	output logic      convert_start_out,
	output logic      sck_out,
	output logic      rden_chain_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		convert_start_out = 1'h0;
		sck_out = 1'h0;
		rden_chain_out = 1'h0;
	end
	// Starts a conversion and counts the core cycles of the busy pulse.
	task automatic convert(output int len);
		len = 0;
		@(posedge clk_in);
		convert_start_out <= 1'h1;
		repeat (2) @(posedge clk_in);
		convert_start_out <= 1'h0;
		for (int i = 0; i < 10 && busy_in !== 1'h1; i++) begin
			@(negedge clk_in);
		end
		while (busy_in === 1'h1 && len < 200) begin
			@(negedge clk_in);
			len++;
		end
	endtask
	// Clocks n bits at the link rate; the serial clock stands still outside frames.
	task automatic shift(input int n, input logic [39:0] up, output logic [39:0] got);
		got = 40'h0;
		#3.2;
		for (int i = 0; i < n; i++) begin
			rden_chain_out = up[n-1-i];
			#7.5;
			got = {got[38:0], sdo_in};
			sck_out = 1'h1;
			#7.5;
			sck_out = 1'h0;
		end
	endtask
	// Sets the read enable level used in normal mode.
	task automatic hold_rden(input logic v);
		rden_chain_out = v;
	endtask
endmodule

/* tb_sar_adc_convert_serial_readout.sv */
// Self-checking bench of the converter control block with a host model.
module tb_sar_adc_convert_serial_readout;
	import sar_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [19:0] UP_WORD = 20'hA5C3E;
	logic        clk_in = 1'h0, resetn_in = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, busy, sdo, sdo_oe, conv, sck, rden, sdo_hold = 1'h0;
	logic        chain_sel = 1'h0, comp_sel = 1'h1;
	wire         sdo_line = (sdo_oe === 1'h1) ? sdo : sdo_hold;
	int          num_errors = 0, cmp_count = 0;
	logic [39:0] scratch;
	logic [31:0] rd_word;
	logic        rd_err;
	always #12.5 clk_in = ~clk_in;
	// A released output line shows the inverse of its last driven level.
	always @(sdo or sdo_oe) begin
		if (sdo_oe === 1'h1) begin
			sdo_hold = ~sdo;
		end
	end
	sar_adc_ctrl i_dut (
		.clk_in                 (clk_in),
		.resetn_in              (resetn_in),
		.psel_in                (psel),
		.penable_in             (penable),
		.pwrite_in              (pwrite),
		.paddr_in               (paddr),
		.pwdata_in              (pwdata),
		.prdata_out             (prdata),
		.pready_out             (pready),
		.pslverr_out            (pslverr),
		.convert_start_in       (conv),
		.chain_select_in        (chain_sel),
		.compression_select_in  (comp_sel),
		.busy_out               (busy),
		.sck_in                 (sck),
		.read_enable_or_chain_in(rden),
		.sdo_out                (sdo),
		.sdo_oe_out             (sdo_oe)
	);
	sar_host_model i_host (
		.clk_in           (clk_in),
		.busy_in          (busy),
		.sdo_in           (sdo_line),
		.convert_start_out(conv),
		.sck_out          (sck),
		.rden_chain_out   (rden)
	);
	////////////////////////////////////////
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n = 0;
		@(posedge clk_in);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_in);
		penable <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'h1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee,
			input string nm);
		logic [31:0] d;
		logic        e;
		apb(1'h0, a, 32'h0, d, e);
		check(nm, {8'h0, exp}, {8'h0, d});
		check("slave error", {39'h0, ee}, {39'h0, e});
	endtask
	// One conversion of a stand-in sample, then register and serial readout.
	task automatic run(input logic [19:0] raw, input logic ch, input logic cp,
			input logic [19:0] exp, input logic [15:0] cnt);
		logic [31:0] d;
		logic        e;
		logic [39:0] got;
		int          len;
		apb(1'h1, ADDR_SAMPLE, {12'h0, raw}, d, e);
		chain_sel <= ch;
		comp_sel <= cp;
		repeat (4) @(posedge clk_in);
		i_host.convert(len);
		check("busy cycles", 40'(CONV_CYCLES), 40'(len));
		rd_chk(ADDR_RESULT, {12'h0, exp}, 1'h0, "result");
		rd_chk(ADDR_COUNT, {16'h0, cnt}, 1'h0, "count");
		apb(1'h0, ADDR_STATUS, 32'h0, d, e);
		check("mode bits", {38'h0, ~cp, ch}, {38'h0, d[3:2]});
		i_host.shift(ch ? 32'h28 : 32'h14, ch ? {UP_WORD, 20'h0} : 40'h0, got);
		check("serial word", ch ? {exp, UP_WORD} : {20'h0, exp}, got);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		fork
			i_host.shift(4, 40'h0, scratch);
			repeat (5) @(posedge clk_in);
		join
		resetn_in <= 1'h1;
		i_host.shift(4, 40'h0, scratch);
		rd_chk(ADDR_CTRL, 32'h1, 1'h0, "ctrl reset");
		rd_chk(ADDR_SAMPLE, 32'h0, 1'h0, "sample reset");
		rd_chk(ADDR_COUNT, 32'h0, 1'h0, "count reset");
		rd_chk(ADDR_STATUS, 32'h0, 1'h0, "status reset");
		rd_chk(8'h14, 32'h0, 1'h1, "unmapped");
		run(20'h7FFFF, 1'h0, 1'h1, 20'h7FFFF, 16'h1);
		run(20'h80001, 1'h0, 1'h1, 20'h80001, 16'h2);
		run(20'h10000, 1'h0, 1'h0, 20'h14000, 16'h3);
		run(20'h70000, 1'h1, 1'h0, 20'h7FFFF, 16'h4);
		run(20'hC0000, 1'h1, 1'h1, 20'hC0000, 16'h5);
		run(20'h80000, 1'h0, 1'h0, 20'h80000, 16'h6);
		rd_chk(ADDR_STATUS, 32'h8, 1'h0, "asleep after conversion");
		apb(1'h1, ADDR_CTRL, 32'h0, rd_word, rd_err);
		rd_chk(ADDR_CTRL, 32'h0, 1'h0, "ctrl written");
		run(20'h00005, 1'h0, 1'h1, 20'h00005, 16'h7);
		rd_chk(ADDR_STATUS, 32'h2, 1'h0, "awake after conversion");
		i_host.hold_rden(1'h1);
		repeat (6) @(posedge clk_in);
		check("sdo enable off", 40'h0, {39'h0, sdo_oe});
		i_host.hold_rden(1'h0);
		repeat (6) @(posedge clk_in);
		check("sdo enable on", 40'h1, {39'h0, sdo_oe});
		end_sim();
	end
	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end
endmodule
